// ---- misc_ctrl_pkg.sv ----
package misc_ctrl_pkg;

  // register byte addresses
  localparam logic [31:0] MISC_CTRL_ADDR  = 32'h5600_0080;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5600_00F0;
  localparam logic [31:0] IRQ_MASK_ADDR   = 32'h5600_00F4;

  // control register layout
  localparam int          ACT_HI        = 22;
  localparam int          ACT_LO        = 20;
  localparam int          REFRESH_BIT   = 19;
  localparam int          MEM_ONE_BIT   = 18;
  localparam int          MEM_ZERO_BIT  = 17;
  localparam int          RST_OUT_BIT   = 16;
  localparam int          SUSP_ONE_BIT  = 13;
  localparam int          SUSP_ZERO_BIT = 12;
  localparam int          PAD_ONE_HI    = 10;
  localparam int          PAD_ONE_LO    = 8;
  localparam int          PAD_ZERO_HI   = 6;
  localparam int          PAD_ZERO_LO   = 4;
  localparam int          ROLE_BIT      = 3;
  localparam int          PD_UPPER_BIT  = 1;
  localparam int          PD_LOWER_BIT  = 0;
  localparam logic [31:0] CTRL_RESET    = 32'h0001_0020;
  localparam logic [31:0] CTRL_WMASK    = 32'h007F_377B;

  // battery fault action codes
  localparam logic [1:0]  ACT_WAKE_IRQ  = 2'h2;
  localparam logic [2:0]  ACT_IGNORE    = 3'h6;
  localparam logic [2:0]  ACT_OFF       = 3'h7;

  // clock pad source codes
  localparam logic [2:0]  SRC_0 = 3'h0;
  localparam logic [2:0]  SRC_1 = 3'h1;
  localparam logic [2:0]  SRC_2 = 3'h2;
  localparam logic [2:0]  SRC_3 = 3'h3;
  localparam logic [2:0]  SRC_4 = 3'h4;
  localparam logic [2:0]  SRC_5 = 3'h5;

  // interrupt status layout
  localparam int          IRQ_BITS      = 2;
  localparam int          IRQ_FAULT     = 0;
  localparam int          IRQ_WAKE      = 1;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [31:0]         ctrl;
    logic [IRQ_BITS-1:0] status;
    logic [IRQ_BITS-1:0] mask;
    logic                fault_meta;
    logic                fault_sync;
    logic                ack;
    logic [31:0]         rdata;
  } state_t;

endpackage : misc_ctrl_pkg

// ---- misc_system_control.sv ----
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps

// Function
// RULE1 - action code 0XX holds the system in reset while battery fault is low
// RULE2 - action 10X: battery fault low wakes the device from sleep
// RULE3 - action 10X: battery fault low in normal mode raises the fault interrupt
// RULE4 - action 110: all wake-up sources ignored in sleep while fault is low
// RULE5 - action 110: battery fault has no effect in normal mode
// RULE6 - action 111: battery fault input function fully disabled
// RULE7 - self-refresh retain bit keeps memory in self-refresh after wake; resets 0
// RULE8 - second memory clock gate: 0 passes memory clock, 1 holds 0; resets 0
// RULE9 - first memory clock gate: 0 passes memory clock, 1 holds 0; resets 0
// RULE10 - reset output level bit drives reset output pin directly; resets 1
// RULE11 - usb port one suspend bit: 1 suspend, 0 normal; resets 0
// RULE12 - usb port zero suspend bit: 1 suspend, 0 normal; resets 0
// RULE13 - second clock pad source select, six sources, 11x reserved; resets 000
// RULE14 - first clock pad source select, six sources, 11x reserved; resets 010
// RULE15 - usb port one role: 0 device, 1 host; resets 0
// RULE16 - upper data pull-downs enabled at 0, disabled at 1; resets 0
// RULE17 - lower data pull-downs enabled at 0, disabled at 1; resets 0
// RULE18 - reset gives documented values; reserved bits read zero, ignore writes
module misc_system_control (
  input  wire logic                    clock,                     // 50 MHz
  input  wire logic                    rst_n,                     // async reset
  input  wire logic                    clock_en,                  // freezes state
  input  wire misc_ctrl_pkg::wb_req_t  wb_req,                    // wishbone request
  output logic                         wb_ack,                    // wishbone ack
  output logic [31:0]                  wb_dat_o,                  // read data
  output logic                         irq,                       // level interrupt
  input  wire logic                    battery_fault_in_n,        // pin, async
  input  wire logic                    sleep_mode,                // power state
  input  wire logic                    wake_source_in,            // other wake events
  output logic                         wake_out,                  // wake to power ctl
  output logic                         hold_in_reset,             // keep system reset
  output logic                         keep_self_refresh_on_wake, // memory retain
  input  wire logic                    mem_clock,                 // memory clock
  output logic                         mem_clock_out_one,         // gated pad
  output logic                         mem_clock_out_zero,        // gated pad
  output logic                         reset_out_pin_n,           // reset pin
  output logic                         usb_port_one_suspend,      // suspend
  output logic                         usb_port_zero_suspend,     // suspend
  output logic                         usb_port_one_role,         // 1 host
  output logic                         upper_data_pulldown_off,   // d31..16
  output logic                         lower_data_pulldown_off,   // d15..0
  input  wire logic                    main_pll,                  // pad source
  input  wire logic                    usb_pll,                   // pad source
  input  wire logic                    rtc_clock,                 // pad source
  input  wire logic                    ahb_clock,                 // pad source
  input  wire logic                    peripheral_clock,          // pad source
  input  wire logic                    crystal_clock,             // pad source
  input  wire logic                    cpu_core_clock,            // pad source
  input  wire logic                    divided_clock_one,         // pad source
  input  wire logic                    divided_clock_zero,        // pad source
  output logic                         clock_pad_one,             // clock pad
  output logic                         clock_pad_zero             // clock pad
);

  misc_ctrl_pkg::state_t state;
  misc_ctrl_pkg::state_t next_state;

  logic       take;
  logic       fault_low;
  logic [2:0] act;
  logic       batt_wake;
  logic       batt_irq_ev;
  logic       wake_block;

  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return res;
  endfunction : byte_merge

  function automatic logic pad_mux(input logic [2:0] code, input logic [5:0] src);
    logic res;
    res = 1'b0;
    case (code)
      misc_ctrl_pkg::SRC_0: res = src[0];
      misc_ctrl_pkg::SRC_1: res = src[1];
      misc_ctrl_pkg::SRC_2: res = src[2];
      misc_ctrl_pkg::SRC_3: res = src[3];
      misc_ctrl_pkg::SRC_4: res = src[4];
      misc_ctrl_pkg::SRC_5: res = src[5];
      default:              res = 1'b0;
    endcase
    return res;
  endfunction : pad_mux

  assign take      = wb_req.cyc & wb_req.stb & ~state.ack;
  assign fault_low = ~state.fault_sync;
  assign act       = state.ctrl[misc_ctrl_pkg::ACT_HI:misc_ctrl_pkg::ACT_LO];

  // battery fault decode
  assign hold_in_reset = ~act[2] & fault_low;                                   // [RULE1]
  assign batt_wake     = sleep_mode & (act[2:1] == misc_ctrl_pkg::ACT_WAKE_IRQ)
                         & fault_low;                                           // [RULE2]
  assign batt_irq_ev   = ~sleep_mode & (act[2:1] == misc_ctrl_pkg::ACT_WAKE_IRQ)
                         & fault_low;                                           // [RULE3]
  assign wake_block    = sleep_mode & (act == misc_ctrl_pkg::ACT_IGNORE)
                         & fault_low;                                           // [RULE4]
  // codes 110 in normal mode and 111 reach none of the terms above [RULE5] [RULE6]
  assign wake_out      = (wake_source_in & ~wake_block) | batt_wake;

  always_comb begin
    next_state            = state;
    next_state.fault_meta = battery_fault_in_n;
    next_state.fault_sync = state.fault_meta;
    next_state.ack        = take;
    if (take) begin
      next_state.rdata = 32'h0000_0000;
      if (wb_req.adr == misc_ctrl_pkg::MISC_CTRL_ADDR) begin
        next_state.rdata = state.ctrl;
        if (wb_req.we) begin
          // reserved bits stay zero [RULE18]
          next_state.ctrl = byte_merge(state.ctrl, wb_req.dat, wb_req.sel)
                            & misc_ctrl_pkg::CTRL_WMASK;
        end
      end else if (wb_req.adr == misc_ctrl_pkg::IRQ_STATUS_ADDR) begin
        next_state.rdata[misc_ctrl_pkg::IRQ_BITS-1:0] = state.status;
        if (!wb_req.we) begin
          next_state.status = '0;
        end
      end else if (wb_req.adr == misc_ctrl_pkg::IRQ_MASK_ADDR) begin
        next_state.rdata[misc_ctrl_pkg::IRQ_BITS-1:0] = state.mask;
        if (wb_req.we && wb_req.sel[0]) begin
          next_state.mask = wb_req.dat[misc_ctrl_pkg::IRQ_BITS-1:0];
        end
      end
    end
    // set wins over the read clear
    if (batt_irq_ev) begin
      next_state.status[misc_ctrl_pkg::IRQ_FAULT] = 1'b1;                      // [RULE3]
    end
    if (batt_wake) begin
      next_state.status[misc_ctrl_pkg::IRQ_WAKE] = 1'b1;                       // [RULE2]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state            <= '0;
      state.ctrl       <= misc_ctrl_pkg::CTRL_RESET;                            // [RULE18]
      state.fault_meta <= 1'b1;
      state.fault_sync <= 1'b1;
    end else if (clock_en) begin
      state <= next_state;
    end
  end

  assign wb_ack   = state.ack;
  assign wb_dat_o = state.rdata;
  assign irq      = |(state.status & state.mask);

  assign keep_self_refresh_on_wake = state.ctrl[misc_ctrl_pkg::REFRESH_BIT];    // [RULE7]
  // and-gating: glitch-free only if the gate bit changes while mem_clock is low
  assign mem_clock_out_one  = mem_clock & ~state.ctrl[misc_ctrl_pkg::MEM_ONE_BIT];  // [RULE8]
  assign mem_clock_out_zero = mem_clock & ~state.ctrl[misc_ctrl_pkg::MEM_ZERO_BIT]; // [RULE9]
  assign reset_out_pin_n       = state.ctrl[misc_ctrl_pkg::RST_OUT_BIT];        // [RULE10]
  assign usb_port_one_suspend  = state.ctrl[misc_ctrl_pkg::SUSP_ONE_BIT];       // [RULE11]
  assign usb_port_zero_suspend = state.ctrl[misc_ctrl_pkg::SUSP_ZERO_BIT];      // [RULE12]
  assign usb_port_one_role     = state.ctrl[misc_ctrl_pkg::ROLE_BIT];           // [RULE15]
  assign upper_data_pulldown_off = state.ctrl[misc_ctrl_pkg::PD_UPPER_BIT];     // [RULE16]
  assign lower_data_pulldown_off = state.ctrl[misc_ctrl_pkg::PD_LOWER_BIT];     // [RULE17]

  // plain muxes; a source switch can cut a pulse short on the pad
  assign clock_pad_one = pad_mux(state.ctrl[misc_ctrl_pkg::PAD_ONE_HI:misc_ctrl_pkg::PAD_ONE_LO],
                                 {divided_clock_one, peripheral_clock, ahb_clock,
                                  rtc_clock, usb_pll, main_pll});               // [RULE13]
  assign clock_pad_zero = pad_mux(state.ctrl[misc_ctrl_pkg::PAD_ZERO_HI:misc_ctrl_pkg::PAD_ZERO_LO],
                                  {divided_clock_zero, peripheral_clock, ahb_clock,
                                   cpu_core_clock, usb_pll, crystal_clock});    // [RULE14]

  sequence s_fault_normal;
    clock_en && !sleep_mode && fault_low && act[2:1] == misc_ctrl_pkg::ACT_WAKE_IRQ;
  endsequence

  sequence s_fault_sleep;
    clock_en && sleep_mode && fault_low && act[2:1] == misc_ctrl_pkg::ACT_WAKE_IRQ;
  endsequence

  property p_hold_reset;
    @(posedge clock) disable iff (!rst_n)
      (!act[2] && !state.fault_sync) |-> hold_in_reset;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("no reset hold on fault"); // [RULE1]

  property p_batt_wake;
    @(posedge clock) disable iff (!rst_n)
      s_fault_sleep |-> wake_out ##1 state.status[misc_ctrl_pkg::IRQ_WAKE];
  endproperty
  a_batt_wake: assert property (p_batt_wake) else $error("fault did not wake"); // [RULE2]

  property p_batt_irq;
    @(posedge clock) disable iff (!rst_n)
      s_fault_normal ##1 (state.mask[misc_ctrl_pkg::IRQ_FAULT] && clock_en) |-> irq;
  endproperty
  a_batt_irq: assert property (p_batt_irq) else $error("fault irq missing"); // [RULE3]

  property p_wake_block;
    @(posedge clock) disable iff (!rst_n)
      (sleep_mode && fault_low && act == misc_ctrl_pkg::ACT_IGNORE) |-> !wake_out;
  endproperty
  a_wake_block: assert property (p_wake_block) else $error("wake not blocked"); // [RULE4]

  property p_normal_ignore;
    @(posedge clock) disable iff (!rst_n)
      (!sleep_mode && act == misc_ctrl_pkg::ACT_IGNORE)
      |-> !hold_in_reset && !batt_irq_ev && wake_out == wake_source_in;
  endproperty
  a_normal_ignore: assert property (p_normal_ignore) else $error("fault acted in normal"); // [RULE5]

  property p_fault_off;
    @(posedge clock) disable iff (!rst_n)
      (act == misc_ctrl_pkg::ACT_OFF)
      |-> !hold_in_reset && !batt_irq_ev && wake_out == wake_source_in;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("fault function not off"); // [RULE6]

  property p_refresh;
    @(posedge clock) disable iff (!rst_n)
      keep_self_refresh_on_wake == state.ctrl[misc_ctrl_pkg::REFRESH_BIT];
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh retain wrong"); // [RULE7]

  property p_mem_one;
    @(posedge clock) disable iff (!rst_n)
      state.ctrl[misc_ctrl_pkg::MEM_ONE_BIT] |-> !mem_clock_out_one;
  endproperty
  a_mem_one: assert property (p_mem_one) else $error("mem clock one not held"); // [RULE8]

  property p_mem_zero;
    @(posedge clock) disable iff (!rst_n)
      !state.ctrl[misc_ctrl_pkg::MEM_ZERO_BIT] |-> mem_clock_out_zero == mem_clock;
  endproperty
  a_mem_zero: assert property (p_mem_zero) else $error("mem clock zero not passed"); // [RULE9]

  property p_rst_out;
    @(posedge clock) disable iff (!rst_n)
      (take && clock_en && wb_req.we && wb_req.sel[2]
       && wb_req.adr == misc_ctrl_pkg::MISC_CTRL_ADDR)
      |=> reset_out_pin_n == $past(wb_req.dat[misc_ctrl_pkg::RST_OUT_BIT]);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset pin level wrong"); // [RULE10]

  property p_suspend;
    @(posedge clock) disable iff (!rst_n)
      {usb_port_one_suspend, usb_port_zero_suspend}
      == state.ctrl[misc_ctrl_pkg::SUSP_ONE_BIT:misc_ctrl_pkg::SUSP_ZERO_BIT];
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend outputs wrong"); // [RULE11] [RULE12]

  property p_pad_one;
    @(posedge clock) disable iff (!rst_n)
      (state.ctrl[misc_ctrl_pkg::PAD_ONE_HI:misc_ctrl_pkg::PAD_ONE_LO] == misc_ctrl_pkg::SRC_2)
      |-> clock_pad_one == rtc_clock;
  endproperty
  a_pad_one: assert property (p_pad_one) else $error("pad one source wrong"); // [RULE13]

  property p_pad_zero;
    @(posedge clock) disable iff (!rst_n)
      (state.ctrl[misc_ctrl_pkg::PAD_ZERO_HI:misc_ctrl_pkg::PAD_ZERO_LO] == misc_ctrl_pkg::SRC_0)
      |-> clock_pad_zero == crystal_clock;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("pad zero source wrong"); // [RULE14]

  property p_role_pd;
    @(posedge clock) disable iff (!rst_n)
      {usb_port_one_role, upper_data_pulldown_off, lower_data_pulldown_off}
      == {state.ctrl[misc_ctrl_pkg::ROLE_BIT], state.ctrl[misc_ctrl_pkg::PD_UPPER_BIT],
          state.ctrl[misc_ctrl_pkg::PD_LOWER_BIT]};
  endproperty
  a_role_pd: assert property (p_role_pd) else $error("role or pull-down wrong"); // [RULE15] [RULE16] [RULE17]

  property p_reserved;
    @(posedge clock) disable iff (!rst_n)
      (state.ctrl & ~misc_ctrl_pkg::CTRL_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // [RULE18]

  property p_ack;
    @(posedge clock) disable iff (!rst_n)
      (take && clock_en) ##1 clock_en |-> wb_ack ##1 !wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

  // a status read taken in this cycle
  logic status_read;
  assign status_read = take & ~wb_req.we & (wb_req.adr == misc_ctrl_pkg::IRQ_STATUS_ADDR);

  sequence s_status_read;
    clock_en && status_read;
  endsequence

  property p_status_clear;
    @(posedge clock) disable iff (!rst_n)
      s_status_read ##0 (!batt_irq_ev && !batt_wake) |=> state.status == '0;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared"); // [RULE3]

  property p_status_sticky;
    @(posedge clock) disable iff (!rst_n)
      (clock_en && !status_read && state.status[misc_ctrl_pkg::IRQ_FAULT])
      |=> state.status[misc_ctrl_pkg::IRQ_FAULT];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status lost"); // [RULE3]

  property p_irq_mask;
    @(posedge clock) disable iff (!rst_n)
      (state.mask == '0) |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised"); // [RULE3]

  property p_ctrl_write;
    @(posedge clock) disable iff (!rst_n)
      (take && clock_en && wb_req.we && wb_req.sel == 4'hF
       && wb_req.adr == misc_ctrl_pkg::MISC_CTRL_ADDR)
      |=> state.ctrl == ($past(wb_req.dat) & misc_ctrl_pkg::CTRL_WMASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write wrong"); // [RULE18]

  property p_ctrl_read;
    @(posedge clock) disable iff (!rst_n)
      (take && clock_en && !wb_req.we && wb_req.adr == misc_ctrl_pkg::MISC_CTRL_ADDR)
      |=> wb_dat_o == $past(state.ctrl);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read wrong"); // [RULE18]

  // enable low must hold every flop, ack and synchroniser included
  property p_freeze;
    @(posedge clock) disable iff (!rst_n)
      !clock_en |=> $stable(state);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_sync;
    @(posedge clock) disable iff (!rst_n)
      clock_en |=> state.fault_sync == $past(state.fault_meta);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser skipped");

  property p_hold_release;
    @(posedge clock) disable iff (!rst_n)
      (act[2] || state.fault_sync) |-> !hold_in_reset;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("reset held wrongly"); // [RULE1]

  // reserved source codes keep the pad quiet
  property p_pad_one_off;
    @(posedge clock) disable iff (!rst_n)
      (state.ctrl[misc_ctrl_pkg::PAD_ONE_HI:misc_ctrl_pkg::PAD_ONE_LO] > misc_ctrl_pkg::SRC_5)
      |-> !clock_pad_one;
  endproperty
  a_pad_one_off: assert property (p_pad_one_off) else $error("pad one not quiet"); // [RULE13]

  property p_pad_zero_off;
    @(posedge clock) disable iff (!rst_n)
      (state.ctrl[misc_ctrl_pkg::PAD_ZERO_HI:misc_ctrl_pkg::PAD_ZERO_LO] > misc_ctrl_pkg::SRC_5)
      |-> !clock_pad_zero;
  endproperty
  a_pad_zero_off: assert property (p_pad_zero_off) else $error("pad zero not quiet"); // [RULE14]

endmodule : misc_system_control

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic                   clock;
  logic                   rst_n;
  logic                   clock_en;
  misc_ctrl_pkg::wb_req_t wb_req;
  logic                   wb_ack;
  logic [31:0]            wb_dat_o;
  logic                   irq;
  logic                   battery_fault_in_n;
  logic                   sleep_mode;
  logic                   wake_source_in;
  logic                   wake_out;
  logic                   hold_in_reset;
  logic                   keep_self_refresh_on_wake;
  logic                   mem_clock;
  logic                   mem_clock_out_one;
  logic                   mem_clock_out_zero;
  logic                   reset_out_pin_n;
  logic                   usb_port_one_suspend;
  logic                   usb_port_zero_suspend;
  logic                   usb_port_one_role;
  logic                   upper_data_pulldown_off;
  logic                   lower_data_pulldown_off;
  logic [8:0]             src;
  logic [31:0]            rdv;
  int                     num_errors;
  int                     check_count;

  misc_system_control u_misc_system_control (
    .clock(clock), .rst_n(rst_n), .clock_en(clock_en), .wb_req(wb_req), .wb_ack(wb_ack),
    .wb_dat_o(wb_dat_o), .irq(irq), .battery_fault_in_n(battery_fault_in_n),
    .sleep_mode(sleep_mode), .wake_source_in(wake_source_in), .wake_out(wake_out),
    .hold_in_reset(hold_in_reset), .keep_self_refresh_on_wake(keep_self_refresh_on_wake),
    .mem_clock(mem_clock), .mem_clock_out_one(mem_clock_out_one),
    .mem_clock_out_zero(mem_clock_out_zero), .reset_out_pin_n(reset_out_pin_n),
    .usb_port_one_suspend(usb_port_one_suspend), .usb_port_zero_suspend(usb_port_zero_suspend),
    .usb_port_one_role(usb_port_one_role), .upper_data_pulldown_off(upper_data_pulldown_off),
    .lower_data_pulldown_off(lower_data_pulldown_off), .main_pll(src[0]), .usb_pll(src[1]),
    .rtc_clock(src[2]), .ahb_clock(src[3]), .peripheral_clock(src[4]),
    .crystal_clock(src[5]), .cpu_core_clock(src[6]), .divided_clock_one(src[7]),
    .divided_clock_zero(src[8]), .clock_pad_one(), .clock_pad_zero());

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // holds the request until ack is sampled high, then releases
  task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) chk("bus ack", 32'h1, 32'h0);
    rdv = wb_dat_o;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(negedge clock);
  endtask : bus

  // fault pin passes a 2-flop synchroniser, so settle a few cycles
  task automatic pin(input logic v, input logic s, input logic w);
    @(posedge clock);
    battery_fault_in_n <= v;
    sleep_mode         <= s;
    wake_source_in     <= w;
    repeat (5) @(posedge clock);
    @(negedge clock);
  endtask : pin

  task automatic t_reset();
    src <= 9'h040;
    bus(1'b0, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0);
    chk("ctrl reset", misc_ctrl_pkg::CTRL_RESET, rdv);
    chk("reset pin", 32'h1, 32'(reset_out_pin_n));
    chk("pad zero", 32'h1, 32'(u_misc_system_control.clock_pad_zero));
    chk("pad one", 32'h0, 32'(u_misc_system_control.clock_pad_one));
  endtask : t_reset

  task automatic t_fields();
    @(posedge clock);
    mem_clock <= 1'b1;
    bus(1'b1, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'hFFFF_FFFF);
    bus(1'b0, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0);
    chk("ctrl ones", misc_ctrl_pkg::CTRL_WMASK, rdv);
    chk("outs ones", 32'h13F, 32'({keep_self_refresh_on_wake, mem_clock_out_one, mem_clock_out_zero,
      reset_out_pin_n, usb_port_one_suspend, usb_port_zero_suspend, usb_port_one_role,
      upper_data_pulldown_off, lower_data_pulldown_off}));
    bus(1'b1, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0);
    chk("outs zero", 32'h0C0, 32'({keep_self_refresh_on_wake, mem_clock_out_one, mem_clock_out_zero,
      reset_out_pin_n, usb_port_one_suspend, usb_port_zero_suspend, usb_port_one_role,
      upper_data_pulldown_off, lower_data_pulldown_off}));
  endtask : t_fields

  task automatic t_pads();
    int          one_map [6];
    int          zero_map [6];
    logic [8:0]  s;
    logic [31:0] c;
    one_map  = '{0, 1, 2, 3, 4, 7};
    zero_map = '{5, 1, 6, 3, 4, 8};
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 8; k++) begin
        c = (p == 1) ? ((32'(k) << 8) | 32'h70) : (32'h700 | (32'(k) << 4));
        bus(1'b1, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0001_0000 | c);
        s = (k > 5) ? 9'h1FF : 9'h001 << ((p == 1) ? one_map[k] : zero_map[k]);
        for (int q = 0; q < 2; q++) begin
          @(posedge clock);
          src <= (q == 1) ? ~s : s;
          @(negedge clock);
          chk("clock pad", (k < 6 && q == 0) ? 32'h1 : 32'h0, 32'((p == 1) ?
            u_misc_system_control.clock_pad_one : u_misc_system_control.clock_pad_zero));
        end
      end
    end
  endtask : t_pads

  task automatic t_batt();
    for (int a = 0; a < 4; a += 3) begin
      bus(1'b1, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0001_0000 | (32'(a) << 20));
      pin(1'b0, 1'b0, 1'b0);
      chk("hold low", 32'h1, 32'(hold_in_reset));
      pin(1'b1, 1'b0, 1'b0);
      chk("hold high", 32'h0, 32'(hold_in_reset));
    end
    bus(1'b1, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0041_0000);
    pin(1'b0, 1'b0, 1'b0);
    chk("irq masked", 32'h0, 32'(irq));
    bus(1'b1, misc_ctrl_pkg::IRQ_MASK_ADDR, 32'h3);
    chk("irq unmasked", 32'h1, 32'(irq));
    pin(1'b1, 1'b0, 1'b0);
    bus(1'b0, misc_ctrl_pkg::IRQ_STATUS_ADDR, 32'h0);
    chk("status fault", 32'h1, rdv);
    bus(1'b0, misc_ctrl_pkg::IRQ_STATUS_ADDR, 32'h0);
    chk("status cleared", 32'h0, rdv);
    chk("irq cleared", 32'h0, 32'(irq));
    bus(1'b1, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0051_0000);
    pin(1'b0, 1'b1, 1'b0);
    chk("wake on fault", 32'h1, 32'(wake_out));
    pin(1'b1, 1'b1, 1'b0);
    bus(1'b0, misc_ctrl_pkg::IRQ_STATUS_ADDR, 32'h0);
    chk("status wake", 32'h2, rdv);
    bus(1'b1, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0061_0000);
    pin(1'b0, 1'b1, 1'b1);
    chk("wake blocked", 32'h0, 32'(wake_out));
    pin(1'b0, 1'b0, 1'b0);
    bus(1'b0, misc_ctrl_pkg::IRQ_STATUS_ADDR, 32'h0);
    chk("ignore normal", 32'h0, {rdv[30:0], irq | hold_in_reset});
    bus(1'b1, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0071_0000);
    pin(1'b0, 1'b1, 1'b1);
    chk("off wake", 32'h1, 32'({wake_out, hold_in_reset} == 2'b10));
    pin(1'b1, 1'b0, 1'b0);
    bus(1'b0, misc_ctrl_pkg::IRQ_STATUS_ADDR, 32'h0);
    chk("off status", 32'h0, rdv);
  endtask : t_batt

  task automatic t_unmapped();
    bus(1'b1, 32'h5600_0100, 32'hFFFF_FFFF);
    bus(1'b0, 32'h5600_0100, 32'h0);
    chk("unmapped", 32'h0, rdv);
    bus(1'b0, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0);
    chk("ctrl kept", 32'h0071_0000, rdv);
  endtask : t_unmapped

  // enable low must freeze the fault synchroniser
  task automatic t_freeze();
    bus(1'b1, misc_ctrl_pkg::MISC_CTRL_ADDR, 32'h0001_0000);
    @(posedge clock);
    clock_en <= 1'b0;
    pin(1'b0, 1'b0, 1'b0);
    chk("frozen hold", 32'h0, 32'(hold_in_reset));
    @(posedge clock);
    clock_en <= 1'b1;
    pin(1'b0, 1'b0, 1'b0);
    chk("thawed hold", 32'h1, 32'(hold_in_reset));
    pin(1'b1, 1'b0, 1'b0);
  endtask : t_freeze

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    #(20 * 20000);
    num_errors++;
    $display("mismatch watchdog expected done seen hang");
    complete_run();
  end

  initial begin
    num_errors         = 0;
    check_count        = 0;
    rst_n              = 1'b0;
    clock_en           = 1'b1;
    wb_req             = '0;
    battery_fault_in_n = 1'b1;
    sleep_mode         = 1'b0;
    wake_source_in     = 1'b0;
    mem_clock          = 1'b0;
    src                = 9'h000;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_pads();
    t_batt();
    t_unmapped();
    t_freeze();
    complete_run();
  end
endmodule : tb_top
